// ---- dv/ewg_slow_mem.sv ----
// slow external device model that counts the cycles it is held
`timescale 1ns/1ns
module ewg_slow_mem (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // bus cycle status seen at the device
  input wire logic acc_busy,
  input wire logic acc_ready,
  // cycles held in the current bus cycle
  output int held_cycles
);
  // ==========================================
  // count held cycles, restart once the cycle completes
  always @(posedge clk_sys) begin
    if (srst || acc_ready) held_cycles <= 0;
    else if (acc_busy) held_cycles <= held_cycles + 1;
  end
endmodule : ewg_slow_mem

// ---- dv/testbench.sv ----
// self-checking bench of the wait-state generator
`timescale 1ns/1ns
module testbench;
  import ewg_pkg::*;
  logic clk_sys, srst, reg_wr, reg_rd, subsystem_select_pin, acc_req, acc_busy, acc_ready;
  logic [3:0] reg_addr, acc_waits;
  logic [15:0] reg_wdata, reg_rdata;
  logic [17:0] acc_addr;
  ewg_space_t acc_space;
  int held, fail_count, cmp_count, seed, r, m, s, a, i;
  // ==========================================
  // design and device model
  ewg_core uut (.clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .subsystem_select_pin(subsystem_select_pin), .acc_req(acc_req), .acc_space(acc_space),
    .acc_addr(acc_addr), .acc_busy(acc_busy), .acc_ready(acc_ready), .acc_waits(acc_waits));
  ewg_slow_mem mem (.clk_sys(clk_sys), .srst(srst), .acc_busy(acc_busy),
    .acc_ready(acc_ready), .held_cycles(held));
  // ==========================================
  // clock
  initial begin
    clk_sys = 0;
    forever #50 clk_sys = ~clk_sys;
  end
  // compare one value
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task wr(input logic [3:0] ad, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= 1;
    @(posedge clk_sys);
    reg_wr <= 0;
  endtask : wr
  task rd(input logic [3:0] ad, input logic [15:0] exp);
    @(posedge clk_sys);
    reg_addr <= ad;
    reg_rd <= 1;
    @(posedge clk_sys);
    reg_rd <= 0;
    @(negedge clk_sys);
    chk(reg_rdata, exp);
  endtask : rd
  // reference wait count from register contents
  function automatic int mw(int rv, int mv, int sv, int av);
    int b;
    if (sv == 2) b = (rv >> 12) & 7;
    else if (sv == 1) b = ((av >> 15) & 1) ? (rv >> 9) & 7 : (rv >> 6) & 7;
    else if (((rv >> 15) & 1) || !((av >> 15) & 1)) b = rv & 7;
    else b = (rv >> 3) & 7;
    b = b * (mv + 1);
    return (b < 1) ? 1 : b;
  endfunction : mw
  // one external access, checked at completion
  task acc(input int sv, input int av, input int exp);
    int n;
    @(posedge clk_sys);
    acc_space <= ewg_space_t'(sv[1:0]);
    acc_addr <= av[17:0];
    acc_req <= 1;
    @(posedge clk_sys);
    acc_req <= 0;
    for (n = 0; n < 40 && acc_ready !== 1'b1; n++) @(negedge clk_sys);
    chk({15'h0000, acc_ready}, 16'h0001);
    chk({12'h000, acc_waits}, exp[15:0]);
    chk(held[15:0], exp[15:0]);
    repeat (2) @(posedge clk_sys);
  endtask : acc
  task tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  // watchdog
  initial begin
    #1000000;
    fail_count++;
    tally_and_finish();
  end
  // ==========================================
  // main sequence
  initial begin
    {reg_wr, reg_rd, acc_req, subsystem_select_pin, reg_addr, reg_wdata, acc_addr} = 0;
    acc_space = EWG_SP_PROG;
    seed = 96;
    srst = 1;
    repeat (5) @(posedge clk_sys);
    srst <= 0;
    rd(4'h0, 16'h7fff);
    rd(4'h3, 16'h0000);
    acc(1, 18'h0_8000, 7);
    wr(4'h1, 16'hffff);
    rd(4'h1, 16'h0001);
    rd(4'h9, 16'h0000);
    $display("reset and register test done");
    for (i = 0; i < 40; i++) begin
      r = $random(seed) & 16'hffff;
      m = $random(seed) & 1;
      s = {$random(seed)} % 3;
      a = $random(seed) & 18'h3_ffff;
      wr(4'h0, r[15:0]);
      wr(4'h1, m[15:0]);
      rd(4'h0, r[15:0]);
      rd(4'h1, m[15:0]);
      acc(s, a, mw(r, m, s, a));
    end
    $display("random range test done");
    wr(4'h0, 16'h7fff);
    wr(4'h1, 16'h0001);
    wr(4'h2, 16'h3000);
    wr(4'h3, 16'hffff);
    subsystem_select_pin <= 1;
    rd(4'h3, 16'h0001);
    repeat (4) @(posedge clk_sys);
    acc(2, 0, 6);
    acc(0, 0, 1);
    subsystem_select_pin <= 0;
    repeat (4) @(posedge clk_sys);
    acc(2, 0, 14);
    $display("owner select test done");
    srst <= 1;
    repeat (2) @(posedge clk_sys);
    srst <= 0;
    rd(4'h0, 16'h7fff);
    rd(4'h2, 16'h7fff);
    rd(4'h1, 16'h0000);
    acc(0, 18'h0_8000, 7);
    $display("second reset test done");
    tally_and_finish();
  end
endmodule : testbench

// ---- rtl/ewg_bank.sv ----
// one subsystem's wait-state register pair
`timescale 1ns/1ns
`include "ewg_map.svh"
module ewg_bank (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // writes to this bank
  input wire logic wr_ranges,
  input wire logic wr_ctrl,
  input wire logic [15:0] wdata,
  // register contents
  output logic [15:0] ranges,
  output logic [15:0] ctrl
);
  // ranges fully writable, control keeps reserved bits at zero
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ranges <= `EWG_RANGES_RST;
      ctrl <= `EWG_CTRL_RST;
    end else begin
      if (wr_ranges) begin
        ranges <= wdata;
      end
      if (wr_ctrl) begin
        ctrl <= {15'h0000, wdata[`EWG_MULT_BIT]};
      end
    end
  end
endmodule : ewg_bank

// ---- rtl/ewg_core.sv ----
// external wait-state generator top
`timescale 1ns/1ns
`include "ewg_map.svh"
module ewg_core (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // owner select pin, asynchronous
  input wire logic subsystem_select_pin,
  // external access request
  input wire logic acc_req,
  input wire ewg_pkg::ewg_space_t acc_space,
  input wire logic [17:0] acc_addr,
  // bus cycle status
  output logic acc_busy,
  output logic acc_ready,
  output logic [3:0] acc_waits
);
  import ewg_pkg::*;

  // ==========================================
  // register file
  logic [15:0] ranges_a;
  logic [15:0] ctrl_a;
  logic [15:0] ranges_b;
  logic [15:0] ctrl_b;
  logic sel_b;
  wire hit_ra = (reg_addr == `EWG_OFF_RANGES_A);
  wire hit_ca = (reg_addr == `EWG_OFF_CTRL_A);
  wire hit_rb = (reg_addr == `EWG_OFF_RANGES_B);
  wire hit_cb = (reg_addr == `EWG_OFF_CTRL_B);

  ewg_bank u_bank_a (
    .clk_sys(clk_sys),
    .srst(srst),
    .wr_ranges(reg_wr & hit_ra),
    .wr_ctrl(reg_wr & hit_ca),
    .wdata(reg_wdata),
    .ranges(ranges_a),
    .ctrl(ctrl_a)
  );
  ewg_bank u_bank_b (
    .clk_sys(clk_sys),
    .srst(srst),
    .wr_ranges(reg_wr & hit_rb),
    .wr_ctrl(reg_wr & hit_cb),
    .wdata(reg_wdata),
    .ranges(ranges_b),
    .ctrl(ctrl_b)
  );
  ewg_sync u_sel_sync (
    .clk_sys(clk_sys),
    .srst(srst),
    .din(subsystem_select_pin),
    .dout(sel_b)
  );

  // read decode, unmapped reads zero
  logic [15:0] rd_mux;
  always_comb begin
    if (hit_ra) begin
      rd_mux = ranges_a;
    end else if (hit_ca) begin
      rd_mux = ctrl_a;
    end else if (hit_rb) begin
      rd_mux = ranges_b;
    end else if (hit_cb) begin
      rd_mux = ctrl_b;
    end else begin
      rd_mux = 16'h0000;
    end
  end

  // read data valid the cycle after the strobe only
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 16'h0000;
    end
  end

  // ==========================================
  // range decode from owning subsystem's registers
  wire [15:0] own_ranges = sel_b ? ranges_b : ranges_a;
  wire own_mult = sel_b ? ctrl_b[`EWG_MULT_BIT] : ctrl_a[`EWG_MULT_BIT];
  wire extended_program_range_bit = own_ranges[`EWG_XPA_BIT];
  wire upper_half = acc_addr[15];
  logic [2:0] base;
  always_comb begin
    if (acc_space == EWG_SP_IO) begin
      base = own_ranges[`EWG_IO_LSB +: 3];
    end else if (acc_space == EWG_SP_DATA && upper_half) begin
      base = own_ranges[`EWG_DHI_LSB +: 3];
    end else if (acc_space == EWG_SP_DATA) begin
      base = own_ranges[`EWG_DLO_LSB +: 3];
    end else if (!extended_program_range_bit && upper_half) begin
      base = own_ranges[`EWG_PHI_LSB +: 3];
    end else begin
      base = own_ranges[`EWG_PLO_LSB +: 3];
    end
  end
  // scale by one or two, at most fourteen
  wire [3:0] scaled = own_mult ? {base, 1'b0} : {1'b0, base};
  // never fewer than one wait
  wire [3:0] next_load = (scaled < `EWG_MIN_WAIT) ? `EWG_MIN_WAIT : scaled;

  // ==========================================
  // bus cycle sequencer
  ewg_state_t state;
  logic [3:0] count;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state <= EWG_IDLE;
      count <= 4'h0;
      acc_busy <= 1'b0;
      acc_ready <= 1'b0;
      acc_waits <= 4'h0;
    end else begin
      acc_ready <= 1'b0;
      case (state)
        EWG_IDLE: begin
          if (acc_req) begin
            state <= EWG_WAIT;
            count <= next_load;
            acc_waits <= next_load;
            acc_busy <= 1'b1;
          end
        end
        EWG_WAIT: begin
          if (count == 4'h1) begin
            state <= EWG_DONE;
            acc_busy <= 1'b0;
            acc_ready <= 1'b1;
          end
          count <= count - 4'h1;
        end
        EWG_DONE: begin
          state <= EWG_IDLE;
        end
        default: begin
          state <= EWG_IDLE;
        end
      endcase
    end
  end

  // ==========================================
  // checks
  sequence s_start;
    acc_req && state == EWG_IDLE;
  endsequence
  property p_min_wait;
    @(posedge clk_sys) disable iff (srst)
      s_start |=> acc_waits >= 4'h1;
  endproperty
  a_min_wait: assert property (p_min_wait) else $error("fewer than one wait");
  property p_max_wait;
    @(posedge clk_sys) disable iff (srst) acc_waits <= `EWG_MAX_WAIT;
  endproperty
  a_max_wait: assert property (p_max_wait) else $error("wait above fourteen");
  property p_busy_len;
    @(posedge clk_sys) disable iff (srst)
      s_start ##1 acc_waits == 4'h1 |-> acc_busy ##1 acc_ready;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("one-wait cycle wrong");
  property p_ready_end;
    @(posedge clk_sys) disable iff (srst)
      acc_ready |-> $past(acc_busy) && !acc_busy;
  endproperty
  a_ready_end: assert property (p_ready_end) else $error("ready without busy");
  property p_double;
    @(posedge clk_sys) disable iff (srst)
      (s_start and (own_mult && base != 3'h0)) |=> !acc_waits[0];
  endproperty
  a_double: assert property (p_double) else $error("doubled count odd");
  property p_single;
    @(posedge clk_sys) disable iff (srst)
      (s_start and (!own_mult && base != 3'h0)) |=> acc_waits == {1'b0, $past(base)};
  endproperty
  a_single: assert property (p_single) else $error("unscaled count wrong");
  property p_io;
    @(posedge clk_sys) disable iff (srst)
      s_start and (acc_space == EWG_SP_IO && !own_mult && own_ranges[14:12] != 3'h0)
      |=> acc_waits == {1'b0, $past(own_ranges[14:12])};
  endproperty
  a_io: assert property (p_io) else $error("io count wrong");
  property p_ctrl_rsv;
    @(posedge clk_sys) disable iff (srst) ctrl_a[15:1] == 15'h0000 && ctrl_b[15:1] == 15'h0000;
  endproperty
  a_ctrl_rsv: assert property (p_ctrl_rsv) else $error("reserved bit set");
  property p_xpa_prog;
    @(posedge clk_sys) disable iff (srst)
      acc_space == EWG_SP_PROG && extended_program_range_bit |-> base == own_ranges[2:0];
  endproperty
  a_xpa_prog: assert property (p_xpa_prog) else $error("extended range field wrong");

  // ==========================================
  // checker helper: length of the running busy stretch
  logic [3:0] busy_run;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      busy_run <= 4'h0;
    end else begin
      busy_run <= acc_busy ? busy_run + 4'h1 : 4'h0;
    end
  end

  // ==========================================
  // reset state of registers and outputs
  property p_rst_vals;
    @(posedge clk_sys)
      srst |=> ranges_a == `EWG_RANGES_RST && ranges_b == `EWG_RANGES_RST
        && ctrl_a == `EWG_CTRL_RST && ctrl_b == `EWG_CTRL_RST
        && !acc_busy && !acc_ready && acc_waits == 4'h0 && reg_rdata == 16'h0000;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("reset values wrong");

  // ==========================================
  // register port
  property p_wr_ranges;
    @(posedge clk_sys) disable iff (srst)
      reg_wr && hit_ra |=> ranges_a == $past(reg_wdata);
  endproperty
  a_wr_ranges: assert property (p_wr_ranges) else $error("range write lost");

  property p_wr_ctrl;
    @(posedge clk_sys) disable iff (srst)
      reg_wr && hit_ca |=> ctrl_a == {15'h0000, $past(reg_wdata[`EWG_MULT_BIT])};
  endproperty
  a_wr_ctrl: assert property (p_wr_ctrl) else $error("control write wrong");

  property p_rd_ranges;
    @(posedge clk_sys) disable iff (srst)
      reg_rd && hit_ra |=> reg_rdata == $past(ranges_a);
  endproperty
  a_rd_ranges: assert property (p_rd_ranges) else $error("range read wrong");

  property p_rd_ctrl;
    @(posedge clk_sys) disable iff (srst)
      reg_rd && (hit_ca || hit_cb) |=> reg_rdata[15:1] == 15'h0000;
  endproperty
  a_rd_ctrl: assert property (p_rd_ctrl) else $error("reserved bits read set");

  property p_rd_idle;
    @(posedge clk_sys) disable iff (srst)
      !reg_rd |=> reg_rdata == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");

  // ==========================================
  // owner select
  sequence s_take_io;
    s_start and (acc_space == EWG_SP_IO);
  endsequence
  property p_sync_lag;
    @(posedge clk_sys) disable iff (srst)
      !$past(srst) && !$past(srst, 2) |-> sel_b == $past(subsystem_select_pin, 2);
  endproperty
  a_sync_lag: assert property (p_sync_lag) else $error("select sync lag wrong");

  property p_own_a;
    @(posedge clk_sys) disable iff (srst)
      s_take_io and (!sel_b && ctrl_a[`EWG_MULT_BIT] && ranges_a[14:12] != 3'h0)
      |=> acc_waits == {$past(ranges_a[14:12]), 1'b0};
  endproperty
  a_own_a: assert property (p_own_a) else $error("owner A count wrong");

  property p_own_b;
    @(posedge clk_sys) disable iff (srst)
      s_take_io and (sel_b && ctrl_b[`EWG_MULT_BIT] && ranges_b[14:12] != 3'h0)
      |=> acc_waits == {$past(ranges_b[14:12]), 1'b0};
  endproperty
  a_own_b: assert property (p_own_b) else $error("owner B count wrong");

  // ==========================================
  // address range decode, unscaled counts
  sequence s_take_data_hi;
    s_start and (acc_space == EWG_SP_DATA && upper_half && !own_mult);
  endsequence
  sequence s_take_data_lo;
    s_start and (acc_space == EWG_SP_DATA && !upper_half && !own_mult);
  endsequence
  sequence s_take_prog_hi;
    s_start and (acc_space == EWG_SP_PROG && !extended_program_range_bit && upper_half && !own_mult);
  endsequence
  sequence s_take_prog_lo;
    s_start and (acc_space == EWG_SP_PROG && !extended_program_range_bit && !upper_half && !own_mult);
  endsequence
  property p_data_hi;
    @(posedge clk_sys) disable iff (srst)
      s_take_data_hi and (own_ranges[11:9] != 3'h0)
      |=> acc_waits == {1'b0, $past(own_ranges[11:9])};
  endproperty
  a_data_hi: assert property (p_data_hi) else $error("upper data count wrong");

  property p_data_lo;
    @(posedge clk_sys) disable iff (srst)
      s_take_data_lo and (own_ranges[8:6] != 3'h0)
      |=> acc_waits == {1'b0, $past(own_ranges[8:6])};
  endproperty
  a_data_lo: assert property (p_data_lo) else $error("lower data count wrong");

  property p_prog_hi;
    @(posedge clk_sys) disable iff (srst)
      s_take_prog_hi and (own_ranges[5:3] != 3'h0)
      |=> acc_waits == {1'b0, $past(own_ranges[5:3])};
  endproperty
  a_prog_hi: assert property (p_prog_hi) else $error("upper program count wrong");

  property p_prog_lo;
    @(posedge clk_sys) disable iff (srst)
      s_take_prog_lo and (own_ranges[2:0] != 3'h0)
      |=> acc_waits == {1'b0, $past(own_ranges[2:0])};
  endproperty
  a_prog_lo: assert property (p_prog_lo) else $error("lower program count wrong");

  // ==========================================
  // bus cycle shape
  property p_busy_count;
    @(posedge clk_sys) disable iff (srst)
      acc_ready |-> busy_run == acc_waits;
  endproperty
  a_busy_count: assert property (p_busy_count) else $error("busy length wrong");

  property p_waits_stable;
    @(posedge clk_sys) disable iff (srst)
      acc_busy && $past(acc_busy) |-> $stable(acc_waits);
  endproperty
  a_waits_stable: assert property (p_waits_stable) else $error("waits changed");

  property p_ready_pulse;
    @(posedge clk_sys) disable iff (srst)
      acc_ready |=> !acc_ready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready too long");

  property p_excl;
    @(posedge clk_sys) disable iff (srst) !(acc_busy && acc_ready);
  endproperty
  a_excl: assert property (p_excl) else $error("busy and ready together");
endmodule : ewg_core

// ---- rtl/ewg_map.svh ----
// register map, field positions and reset values of the wait-state generator
//
// Summary of operation
// - bus cycles stretched up to fourteen waits
// - every external access gets one wait minimum
// - select pin picks owning subsystem's settings
// - five three-bit base counts in low bits
// - multiplier flag scales base by one or two
// - reset gives seven waits, fields read 111
// - bit 15 selects program range mapping
// - bits 14-12 count for I/O space
// - bits 11-9 count for upper data space
// - bits 8-6 count for lower data space
// - bits 5-3 upper program, unused when extended
// - bits 2-0 lower or whole program space
// - control bit 0 multiplier, others reserved zero
// - flag 1 doubles count, maximum fourteen
// - reserved control bits ignore writes
`ifndef EWG_MAP_SVH
`define EWG_MAP_SVH
// ==========================================
// register offsets (two copies, one per subsystem)
`define EWG_OFF_RANGES_A 4'h0
`define EWG_OFF_CTRL_A 4'h1
`define EWG_OFF_RANGES_B 4'h2
`define EWG_OFF_CTRL_B 4'h3
// ==========================================
// field positions
`define EWG_XPA_BIT 15
`define EWG_IO_LSB 12
`define EWG_DHI_LSB 9
`define EWG_DLO_LSB 6
`define EWG_PHI_LSB 3
`define EWG_PLO_LSB 0
`define EWG_MULT_BIT 0
// ==========================================
// reset values
`define EWG_RANGES_RST 16'h7fff
`define EWG_CTRL_RST 16'h0000
// ==========================================
// timing counts
`define EWG_MIN_WAIT 4'h1
`define EWG_MAX_WAIT 4'he
`endif

// ---- rtl/ewg_pkg.sv ----
// types of the wait-state generator
package ewg_pkg;
  typedef enum logic [1:0] {
    EWG_IDLE = 2'b00,
    EWG_WAIT = 2'b01,
    EWG_DONE = 2'b10
  } ewg_state_t;
  typedef enum logic [1:0] {
    EWG_SP_PROG = 2'b00,
    EWG_SP_DATA = 2'b01,
    EWG_SP_IO = 2'b10
  } ewg_space_t;
endpackage : ewg_pkg

// ---- rtl/ewg_sync.sv ----
// two-flop synchroniser for one pin
`timescale 1ns/1ns
module ewg_sync (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // pin and synchronised level
  input wire logic din,
  output logic dout
);
  logic meta;
  // first stage feeds only the second
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      meta <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule : ewg_sync
